// ### verilog/bcm_decode_top.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "bcm_map.svh"

module bcm_decode_top
    import bcm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output bcm_mem_s mem_o,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    input wire logic wake,
    output logic sleeping,
    output logic busy
);

    bcm_regs_s r_q; // Registered state
    bcm_regs_s r_d; // Next state
    bcm_fields_s f; // Fields of the held instruction
    logic cond_true; // Branch test result
    logic wr_ok; // Accepted APB write
    logic [23:0] step; // Bytes the held instruction occupies
    logic [23:0] pc_next; // Address of the following instruction

    // True when an offset is one of ours
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `BCM_OFF_PC) || (a == `BCM_OFF_FLAGS) || (a == `BCM_OFF_EXT) ||
            (a == `BCM_OFF_INSTR) || (a == `BCM_OFF_SRC) || (a == `BCM_OFF_DST) ||
            (a == `BCM_OFF_COUNT) || (a == `BCM_OFF_RET) || (a == `BCM_OFF_STATUS) ||
            (a == `BCM_OFF_STORE) || (a == `BCM_OFF_EXC_PC);
    endfunction

    // True when the active count has run out
    function automatic logic count_zero(input logic wide, input logic [15:0] cnt);
        return wide ? (cnt == 16'h0000) : (cnt[7:0] == 8'h00);
    endfunction

    // Read multiplexer for the APB side
    function automatic logic [31:0] read_mux(input logic [7:0] a, input bcm_regs_s s);
        logic [31:0] v;
        v = `BCM_RST_WORD;
        unique case (a)
            `BCM_OFF_PC: v = {8'h00, s.pc};
            `BCM_OFF_FLAGS: v = {24'h000000, s.flags};
            `BCM_OFF_EXT: v = s.ext;
            `BCM_OFF_INSTR: v = {16'h0000, s.instr};
            `BCM_OFF_SRC: v = {8'h00, s.src};
            `BCM_OFF_DST: v = {8'h00, s.dst};
            `BCM_OFF_COUNT: v = {16'h0000, s.count};
            `BCM_OFF_RET: v = {8'h00, s.ret};
            `BCM_OFF_STORE: v = {24'h000000, s.store};
            `BCM_OFF_EXC_PC: v = {8'h00, s.exc_pc};
            `BCM_OFF_STATUS: begin
                v[`BCM_STAT_BUSY] = (s.st != ST_IDLE);
                v[`BCM_STAT_SLEEP] = (s.st == ST_SLEEP);
                v[`BCM_STAT_TRAP] = s.trapped;
                v[`BCM_STAT_ILLEGAL] = s.illegal;
                v[`BCM_STAT_TAKEN] = s.taken;
            end
            default: v = `BCM_RST_WORD;
        endcase
        return v;
    endfunction

    // Field splitter on the held instruction
    bcm_field_split u_split (
        .instr(r_q.instr),
        .ext(r_q.ext),
        .fields(f)
    );

    bcm_cond_eval u_cond (
        .cond(f.cond),
        .flags(r_q.flags),
        .taken(cond_true)
    );

    assign step = `BCM_WORD_BYTES + 24'({f.ext_words, 1'b0});
    assign pc_next = r_q.pc + step;

    // Writes land only while idle and not refused at setup
    assign wr_ok = psel && penable && pwrite && !r_q.slverr && (r_q.st == ST_IDLE);

    // Next-state logic for the whole block
    always_comb begin
        r_d = r_q;
        // Setup phase: latch read data and the verdict
        if (psel && !penable) begin
            r_d.rdata = read_mux(paddr, r_q);
            r_d.slverr = !is_mapped(paddr) || (pwrite && (r_q.st != ST_IDLE));
        end
        // Register writes from software
        if (wr_ok) begin
            unique case (paddr)
                `BCM_OFF_PC: r_d.pc = pwdata[23:0];
                `BCM_OFF_FLAGS: r_d.flags = pwdata[7:0];
                `BCM_OFF_EXT: r_d.ext = pwdata;
                `BCM_OFF_SRC: r_d.src = pwdata[23:0];
                `BCM_OFF_DST: r_d.dst = pwdata[23:0];
                `BCM_OFF_COUNT: r_d.count = pwdata[15:0];
                `BCM_OFF_RET: r_d.ret = pwdata[23:0];
                `BCM_OFF_EXC_PC: r_d.exc_pc = pwdata[23:0];
                `BCM_OFF_INSTR: begin
                    // Writing an instruction starts its execution
                    r_d.instr = pwdata[15:0];
                    r_d.st = ST_EXEC;
                    r_d.trapped = 1'b0;
                    r_d.illegal = 1'b0;
                    r_d.taken = 1'b0;
                end
                default: r_d.st = r_q.st;
            endcase
        end
        unique case (r_q.st)
            // Waiting for software
            ST_IDLE: r_d.mem.req = 1'b0;
            // One-cycle decode and execute
            ST_EXEC: begin
                r_d.st = ST_IDLE;
                r_d.pc = pc_next;
                unique case (f.op)
                    OP_NOP: r_d.pc = pc_next;
                    OP_BCC: begin
                        if (cond_true) begin
                            r_d.pc = f.addr24;
                            r_d.taken = 1'b1;
                        end
                    end
                    OP_JUMP: begin
                        r_d.pc = f.addr24;
                        r_d.taken = 1'b1;
                    end
                    OP_RCALL: begin
                        r_d.ret = pc_next;
                        r_d.pc = pc_next + {{8{f.disp16[15]}}, f.disp16};
                        r_d.taken = 1'b1;
                    end
                    OP_ACALL: begin
                        r_d.ret = pc_next;
                        r_d.pc = f.addr24;
                        r_d.taken = 1'b1;
                    end
                    OP_RET: r_d.pc = r_q.ret;
                    OP_TRAP: begin
                        r_d.exc_pc = pc_next;
                        r_d.exc_flags = r_q.flags;
                        r_d.pc = `BCM_TRAP_BASE + 24'({f.imm8[1:0], 2'b00});
                        r_d.trapped = 1'b1;
                    end
                    OP_RTE: begin
                        r_d.pc = r_q.exc_pc;
                        r_d.flags = r_q.exc_flags;
                    end
                    OP_SLEEP: r_d.st = ST_SLEEP;
                    OP_LDF: begin
                        // memory source is a word read
                        if (f.op2[0]) begin
                            r_d.st = ST_FL_RD;
                            r_d.mem = '{1'b1, 1'b0, 1'b1, f.addr24, 16'h0000};
                        end else begin
                            r_d.flags = f.imm8;
                        end
                    end
                    OP_STF: begin
                        // memory destination is a word write
                        if (f.op2[0]) begin
                            r_d.st = ST_FL_WR;
                            r_d.mem = '{1'b1, 1'b1, 1'b1, f.addr24, {r_q.flags, 8'h00}};
                        end else begin
                            r_d.store = r_q.flags;
                        end
                    end
                    OP_ANDF: r_d.flags = r_q.flags & f.imm8;
                    OP_ORF: r_d.flags = r_q.flags | f.imm8;
                    OP_XORF: r_d.flags = r_q.flags ^ f.imm8;
                    OP_MOVE: begin
                        r_d.wide = f.op2[0];
                        if (!count_zero(f.op2[0], r_q.count)) begin
                            r_d.st = ST_MV_RD;
                        end
                    end
                    // Unused opcode is skipped and reported
                    OP_BAD: r_d.illegal = 1'b1;
                endcase
                // Out-of-range long address is reported; its low 24 bits are still used
                if ((f.ext_words == 2'd2) && !f.addr_ok) begin
                    r_d.illegal = 1'b1;
                end
            end
            // Byte read from the source pointer
            ST_MV_RD: begin
                if (r_q.mem.req && mem_ack) begin
                    r_d.data = mem_rdata[7:0];
                    r_d.mem.req = 1'b0;
                    r_d.st = ST_MV_WR;
                end else if (!r_q.mem.req) begin
                    r_d.mem = '{1'b1, 1'b0, 1'b0, r_q.src, 16'h0000};
                end
            end
            // Byte write to the destination pointer
            ST_MV_WR: begin
                if (r_q.mem.req && mem_ack) begin
                    r_d.mem.req = 1'b0;
                    r_d.src = r_q.src + 24'h000001;
                    r_d.dst = r_q.dst + 24'h000001;
                    if (r_q.wide) begin
                        r_d.count = r_q.count - 16'h0001;
                    end else begin
                        r_d.count[7:0] = r_q.count[7:0] - 8'h01;
                    end
                    // stop at once on the last byte
                    r_d.st = count_zero(r_q.wide, r_d.count) ? ST_IDLE : ST_MV_RD;
                end else if (!r_q.mem.req) begin
                    r_d.mem = '{1'b1, 1'b1, 1'b0, r_q.dst, {8'h00, r_q.data}};
                end
            end
            // Word read for load flags, upper byte kept
            ST_FL_RD: begin
                if (mem_ack) begin
                    r_d.flags = mem_rdata[15:8];
                    r_d.mem.req = 1'b0;
                    r_d.st = ST_IDLE;
                end
            end
            // Word write for store flags
            ST_FL_WR: begin
                if (mem_ack) begin
                    r_d.mem.req = 1'b0;
                    r_d.st = ST_IDLE;
                end
            end
            // Low power until woken
            ST_SLEEP: begin
                if (wake) begin
                    r_d.st = ST_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{st: ST_IDLE, pc: `BCM_RST_PC, flags: `BCM_RST_FLAGS,
                ext: `BCM_RST_WORD, rdata: `BCM_RST_WORD, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs
    assign prdata = r_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && r_q.slverr;
    assign mem_o = r_q.mem;
    assign sleeping = (r_q.st == ST_SLEEP);
    assign busy = (r_q.st != ST_IDLE);

    // Checks run on pclk and pause in reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic ex; // Executing this cycle
    assign ex = (r_q.st == ST_EXEC);

    chk_branch_true: assert property (
        ex && f.op == OP_BCC && cond_true |=> r_q.pc == $past(f.addr24))
        else $error("taken branch did not load target");

    chk_branch_false: assert property (
        ex && f.op == OP_BCC && !cond_true |=> r_q.pc == $past(r_q.pc) + 24'h000006)
        else $error("untaken branch did not skip");

    chk_flag_tests: assert property (
        ex && f.op == OP_BCC && f.cond == CC_EQ |-> cond_true == r_q.flags[`BCM_FLAG_Z])
        else $error("equal test wrong");

    chk_signed_tests: assert property (
        ex && f.op == OP_BCC && f.cond == CC_GT |-> cond_true ==
        !(r_q.flags[`BCM_FLAG_Z] | (r_q.flags[`BCM_FLAG_N] ^ r_q.flags[`BCM_FLAG_V])))
        else $error("greater test wrong");

    chk_call_return: assert property (
        ex && f.op == OP_RET |=> r_q.pc == $past(r_q.ret) && r_q.st == ST_IDLE)
        else $error("return missed saved point");

    chk_trap_entry: assert property (
        ex && f.op == OP_TRAP |=> r_q.trapped && r_q.exc_pc == $past(pc_next))
        else $error("trap not entered");

    chk_nop_only_pc: assert property (
        ex && f.op == OP_NOP |=> r_q.pc == $past(r_q.pc) + 24'h000002 && $stable(r_q.flags))
        else $error("no operation changed more than PC");

    chk_flag_and: assert property (
        ex && f.op == OP_ANDF |=> r_q.flags == ($past(r_q.flags) & $past(f.imm8)))
        else $error("flag AND wrong");

    chk_move_zero: assert property (
        ex && f.op == OP_MOVE && count_zero(f.op2[0], r_q.count) |=>
        r_q.st == ST_IDLE ##1 !r_q.mem.req)
        else $error("zero count move touched memory");

    chk_move_done: assert property (
        r_q.st == ST_MV_WR && r_q.mem.req && mem_ack && count_zero(r_q.wide, r_d.count)
        |=> r_q.st == ST_IDLE)
        else $error("move did not finish on last byte");

    chk_sleep_entry: assert property (
        ex && f.op == OP_SLEEP |=> sleeping [*2] or (sleeping ##1 !sleeping))
        else $error("sleep not entered");

    cov_branch_taken: cover property (ex && f.op == OP_BCC && cond_true);
    cov_move_run: cover property (r_q.st == ST_MV_WR ##1 r_q.st == ST_MV_RD);
    cov_trap_rte: cover property (r_q.trapped && ex && f.op == OP_RTE);

endmodule

// ### verilog/bcm_map.svh
`ifndef BCM_MAP_SVH
`define BCM_MAP_SVH

// Register byte offsets on the APB side
`define BCM_OFF_PC 8'h00
`define BCM_OFF_FLAGS 8'h04
`define BCM_OFF_EXT 8'h08
`define BCM_OFF_INSTR 8'h0C
`define BCM_OFF_SRC 8'h10
`define BCM_OFF_DST 8'h14
`define BCM_OFF_COUNT 8'h18
`define BCM_OFF_RET 8'h1C
`define BCM_OFF_STATUS 8'h20
`define BCM_OFF_STORE 8'h24
`define BCM_OFF_EXC_PC 8'h28

// Reset values
`define BCM_RST_PC 24'h000000
`define BCM_RST_FLAGS 8'h00
`define BCM_RST_WORD 32'h00000000

// Flag bit positions inside the flags register
`define BCM_FLAG_C 0
`define BCM_FLAG_V 1
`define BCM_FLAG_Z 2
`define BCM_FLAG_N 3

// Status register bit positions
`define BCM_STAT_BUSY 0
`define BCM_STAT_SLEEP 1
`define BCM_STAT_TRAP 2
`define BCM_STAT_ILLEGAL 3
`define BCM_STAT_TAKEN 4

// Trap vector table base; vector n sits at base plus four times n
`define BCM_TRAP_BASE 24'h000010

// Bytes in one instruction word
`define BCM_WORD_BYTES 24'h000002

`endif

// ### verilog/bcm_pkg.sv
package bcm_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_EXEC, ST_MV_RD, ST_MV_WR, ST_FL_RD, ST_FL_WR, ST_SLEEP
    } bcm_state_e;

    // Primary opcode, top four bits of the instruction word
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_BCC = 4'h1, OP_JUMP = 4'h2, OP_RCALL = 4'h3,
        OP_ACALL = 4'h4, OP_RET = 4'h5, OP_TRAP = 4'h6, OP_RTE = 4'h7,
        OP_SLEEP = 4'h8, OP_LDF = 4'h9, OP_STF = 4'hA, OP_ANDF = 4'hB,
        OP_ORF = 4'hC, OP_XORF = 4'hD, OP_MOVE = 4'hE, OP_BAD = 4'hF
    } bcm_op_e;

    // Branch tests held in the condition field
    typedef enum logic [3:0] {
        CC_ALWAYS = 4'h0, CC_NEVER = 4'h1, CC_HIGH = 4'h2, CC_LOW_SAME = 4'h3,
        CC_CARRY_CLR = 4'h4, CC_CARRY_SET = 4'h5, CC_NOT_EQ = 4'h6, CC_EQ = 4'h7,
        CC_NO_OVF = 4'h8, CC_OVF = 4'h9, CC_PLUS = 4'hA, CC_MINUS = 4'hB,
        CC_GE = 4'hC, CC_LT = 4'hD, CC_GT = 4'hE, CC_LE = 4'hF
    } bcm_cond_e;

    // Fields split out of one instruction plus its extension
    typedef struct packed {
        bcm_op_e op;
        logic [3:0] op2;
        bcm_cond_e cond;
        logic [2:0] areg;
        logic [3:0] dreg;
        logic [7:0] imm8;
        logic [1:0] ext_words;
        logic [23:0] addr24;
        logic addr_ok;
        logic [15:0] disp16;
    } bcm_fields_s;

    // Request to the memory and fetch bus
    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } bcm_mem_s;

    // Entire state of the decoder
    typedef struct packed {
        bcm_state_e st;
        logic [23:0] pc;
        logic [7:0] flags;
        logic [31:0] ext;
        logic [15:0] instr;
        logic [23:0] src;
        logic [23:0] dst;
        logic [15:0] count;
        logic [23:0] ret;
        logic [23:0] exc_pc;
        logic [7:0] exc_flags;
        logic [7:0] store;
        logic [7:0] data;
        logic wide;
        logic trapped;
        logic illegal;
        logic taken;
        bcm_mem_s mem;
        logic [31:0] rdata;
        logic slverr;
    } bcm_regs_s;

endpackage

// ### verilog/bcm_cond_eval.sv
`timescale 1ns/1ps
`include "bcm_map.svh"

// Evaluates one branch test against the current flags
module bcm_cond_eval
    import bcm_pkg::*;
(
    input wire bcm_cond_e cond,
    input wire logic [7:0] flags,
    output logic taken
);

    logic c, z, v, n;

    // Flag taps
    assign c = flags[`BCM_FLAG_C];
    assign z = flags[`BCM_FLAG_Z];
    assign v = flags[`BCM_FLAG_V];
    assign n = flags[`BCM_FLAG_N];

    // Sixteen tests, every code legal
    always_comb begin
        unique case (cond)
            CC_ALWAYS: taken = 1'b1;
            CC_NEVER: taken = 1'b0;
            CC_HIGH: taken = !(c | z);
            CC_LOW_SAME: taken = c | z;
            CC_CARRY_CLR: taken = !c;
            CC_CARRY_SET: taken = c;
            CC_NOT_EQ: taken = !z;
            CC_EQ: taken = z;
            CC_NO_OVF: taken = !v;
            CC_OVF: taken = v;
            CC_PLUS: taken = !n;
            CC_MINUS: taken = n;
            CC_GE: taken = !(n ^ v);
            CC_LT: taken = n ^ v;
            CC_GT: taken = !(z | (n ^ v));
            CC_LE: taken = z | (n ^ v);
        endcase
    end

endmodule

// ### verilog/bcm_field_split.sv
`timescale 1ns/1ps
`include "bcm_map.svh"

// Splits an instruction word and its extension into fields
module bcm_field_split
    import bcm_pkg::*;
(
    input wire logic [15:0] instr,
    input wire logic [31:0] ext,
    output bcm_fields_s fields
);

    always_comb begin
        fields.op = bcm_op_e'(instr[15:12]);
        fields.op2 = instr[11:8];
        fields.cond = bcm_cond_e'(instr[11:8]);
        fields.areg = instr[6:4];
        fields.dreg = instr[3:0];
        fields.imm8 = instr[7:0];
        unique case (bcm_op_e'(instr[15:12]))
            OP_BCC, OP_JUMP, OP_ACALL: fields.ext_words = 2'd2;
            OP_RCALL: fields.ext_words = 2'd1;
            OP_LDF, OP_STF: fields.ext_words = instr[8] ? 2'd2 : 2'd0;
            default: fields.ext_words = 2'd0;
        endcase
        // top byte of address must be zero
        fields.addr24 = ext[23:0];
        fields.addr_ok = (ext[31:24] == 8'h00);
        fields.disp16 = ext[15:0];
    end

endmodule

// ### testbench/bcm_mem_model.sv
`timescale 1ns/1ps
// Memory and fetch bus partner, answering after a chosen delay
module bcm_mem_model
    import bcm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire bcm_mem_s mem_i,
    input wire logic [1:0] delay,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    output logic last_word
);
    logic [7:0] mem [1024];
    logic [1:0] wait_q;
    logic [9:0] a;
    assign a = mem_i.addr[9:0];
    // Pattern differs in each quarter so copies are visible
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 8'(i) ^ {2'(i >> 8), 2'(i >> 8), 4'h5};
        end
    end
    // One ack pulse per request; idle data toggles so stale values never match
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_q <= 2'h0;
            mem_rdata <= 16'hA5A5;
            last_word <= 1'b0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_i.req && !mem_ack && wait_q != delay) begin
                wait_q <= wait_q + 2'h1;
            end else if (mem_i.req && !mem_ack) begin
                wait_q <= 2'h0;
                mem_ack <= 1'b1;
                last_word <= mem_i.word;
                if (mem_i.we) begin
                    mem[a] <= mem_i.word ? mem_i.wdata[15:8] : mem_i.wdata[7:0];
                end
                if (mem_i.we && mem_i.word) begin
                    mem[a + 10'h001] <= mem_i.wdata[7:0];
                end
                if (!mem_i.we) begin
                    mem_rdata <= mem_i.word ? {mem[a], mem[a + 10'h001]} : {~mem[a], mem[a]};
                end
            end
        end
    end
endmodule

// ### testbench/cpu_branch_sysctl_block_move_decode_test.sv
`timescale 1ns/1ps
`include "bcm_map.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module cpu_branch_sysctl_block_move_decode_test;
    import bcm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic wake = 1'b0, pready, pslverr, mem_ack, sleeping, busy, ev, lw;
    logic [7:0] paddr = 8'h00, f;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [15:0] mem_rdata, lfsr = 16'h48C5;
    logic [1:0] delay = 2'h0;
    logic [23:0] pc, tg;
    bcm_mem_s mem_o;
    int err_total = 0, cmp_count = 0;
    bcm_decode_top i_bcm_decode_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_o(mem_o),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wake(wake), .sleeping(sleeping),
        .busy(busy));
    bcm_mem_model i_bcm_mem_model (.pclk(pclk), .presetn(presetn), .mem_i(mem_o),
        .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .last_word(lw));
    initial forever #10 pclk = ~pclk;
    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] pat(logic [9:0] a);
        return a[7:0] ^ {a[9:8], a[9:8], 4'h5};
    endfunction
    // Expected outcome of one branch test on flags C0 V1 Z2 N3
    function automatic logic cond_ok(logic [3:0] c, logic [7:0] fl);
        logic r;
        case (c[3:1])
            3'h0: r = 1'b1;
            3'h1: r = ~(fl[0] | fl[2]);
            3'h2: r = ~fl[0];
            3'h3: r = ~fl[2];
            3'h4: r = ~fl[1];
            3'h5: r = ~fl[3];
            3'h6: r = ~(fl[3] ^ fl[1]);
            default: r = ~(fl[2] | (fl[3] ^ fl[1]));
        endcase
        return r ^ c[0];
    endfunction
    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rv)
    endtask
    task automatic chm(input logic [9:0] a, input logic [7:0] e);
        `CHK($sformatf("mem %h", a), e, i_bcm_mem_model.mem[a])
    endtask
    // Issue one instruction and poll status until idle or asleep
    task automatic run(input logic [15:0] ins, input logic [31:0] ext);
        apb(1'b1, `BCM_OFF_EXT, ext);
        apb(1'b1, `BCM_OFF_INSTR, {16'h0000, ins});
        do begin
            apb(1'b0, `BCM_OFF_STATUS, 32'h0);
        end while (rv[0] === 1'b1 && rv[1] !== 1'b1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        err_total++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk(`BCM_OFF_PC, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 1'b1, ev)
        // Random flags and addresses through every branch test
        for (int i = 0; i < 48; i++) begin
            lfsr = nx(lfsr);
            f = {4'h0, lfsr[3:0]};
            pc = {8'h00, lfsr[15:1], 1'b0};
            tg = {lfsr[7:0], lfsr[14:0], 1'b0};
            apb(1'b1, `BCM_OFF_FLAGS, {24'h0, f});
            apb(1'b1, `BCM_OFF_PC, {8'h00, pc});
            run({4'h1, 4'(i), 8'h00}, {8'h00, tg});
            `CHK("taken", cond_ok(4'(i), f), rv[4])
            tg = cond_ok(4'(i), f) ? tg : pc + 24'h000006;
            chk(`BCM_OFF_PC, {8'h00, tg});
        end
        apb(1'b1, `BCM_OFF_PC, 32'h100);
        run(16'h2000, 32'h400);
        `CHK("illegal", 1'b0, rv[3])
        chk(`BCM_OFF_PC, 32'h400);
        run(16'h4000, 32'h800);
        chk(`BCM_OFF_PC, 32'h800);
        run(16'h5000, 32'h0);
        chk(`BCM_OFF_PC, 32'h406);
        run(16'h3000, 32'hFFF0);
        chk(`BCM_OFF_PC, 32'h3FA);
        run(16'h5000, 32'h0);
        chk(`BCM_OFF_PC, 32'h40A);
        run(16'h2000, 32'h1000500);
        `CHK("illegal", 1'b1, rv[3])
        run(16'h0000, 32'h0);
        chk(`BCM_OFF_PC, 32'h502);
        chk(`BCM_OFF_FLAGS, {24'h0, f});
        run(16'hF000, 32'h0);
        `CHK("bad opcode", 1'b1, rv[3])
        // Flag logic with random operands, one opcode after another
        for (int i = 0; i < 12; i++) begin
            lfsr = nx(lfsr);
            apb(1'b1, `BCM_OFF_FLAGS, {24'h0, lfsr[15:8]});
            run({4'hB + 4'(i % 3), 4'h0, lfsr[7:0]}, 32'h0);
            f = i % 3 == 0 ? lfsr[15:8] & lfsr[7:0] : lfsr[15:8] | lfsr[7:0];
            f = i % 3 == 2 ? lfsr[15:8] ^ lfsr[7:0] : f;
            chk(`BCM_OFF_FLAGS, {24'h0, f});
        end
        run(16'h90C3, 32'h0);
        chk(`BCM_OFF_FLAGS, 32'hC3);
        run(16'h9100, 32'h20);
        chk(`BCM_OFF_FLAGS, {24'h0, pat(10'h020)});
        `CHK("word read", 1'b1, lw)
        run(16'hA100, 32'h30);
        chm(10'h030, pat(10'h020));
        chm(10'h031, 8'h00);
        `CHK("word write", 1'b1, lw)
        run(16'hA000, 32'h0);
        chk(`BCM_OFF_STORE, {24'h0, pat(10'h020)});
        // Trap, disturb flags, then return from the handler
        apb(1'b1, `BCM_OFF_PC, 32'h600);
        run(16'h6003, 32'h0);
        `CHK("trapped", 1'b1, rv[2])
        chk(`BCM_OFF_PC, {8'h00, `BCM_TRAP_BASE + 24'h00000C});
        chk(`BCM_OFF_EXC_PC, 32'h602);
        run(16'hC0F0, 32'h0);
        run(16'h7000, 32'h0);
        chk(`BCM_OFF_PC, 32'h602);
        chk(`BCM_OFF_FLAGS, {24'h0, pat(10'h020)});
        // Sleep refuses writes until woken
        run(16'h8000, 32'h0);
        `CHK("sleeping", 1'b1, sleeping)
        `CHK("busy asleep", 1'b1, busy)
        apb(1'b1, `BCM_OFF_PC, 32'h0);
        `CHK("refused", 1'b1, ev)
        @(posedge pclk);
        wake <= 1'b1;
        for (int n = 0; n < 20 && sleeping !== 1'b0; n++) @(posedge pclk);
        wake <= 1'b0;
        `CHK("woken", 1'b0, sleeping)
        `CHK("busy woken", 1'b0, busy)
        // Byte count move with a slow memory; upper count byte ignored
        delay <= 2'h2;
        apb(1'b1, `BCM_OFF_SRC, 32'h40);
        apb(1'b1, `BCM_OFF_DST, 32'h200);
        apb(1'b1, `BCM_OFF_COUNT, 32'h0103);
        run(16'hE000, 32'h0);
        for (int i = 0; i < 3; i++) chm(10'h200 + 10'(i), pat(10'h040 + 10'(i)));
        chm(10'h203, pat(10'h203));
        chk(`BCM_OFF_SRC, 32'h43);
        run(16'hE000, 32'h0);
        chk(`BCM_OFF_DST, 32'h203);
        // Word count move of 258 bytes, then a zero count
        delay <= 2'h0;
        apb(1'b1, `BCM_OFF_SRC, 32'h0);
        apb(1'b1, `BCM_OFF_DST, 32'h280);
        apb(1'b1, `BCM_OFF_COUNT, 32'h0102);
        run(16'hE100, 32'h0);
        chm(10'h381, pat(10'h101));
        chk(`BCM_OFF_COUNT, 32'h0);
        run(16'hE100, 32'h0);
        chk(`BCM_OFF_SRC, 32'h102);
        report_and_stop;
    end
endmodule
